// [ppr_pkg.sv]
package ppr_pkg;

  // selector widths and table sizes
  localparam int IN_SEL_W = 7;
  localparam int OUT_SEL_W = 6;
  localparam int IDX_W = 5;
  localparam int N_IO = 11;
  localparam int N_INO = 8;
  localparam int N_PIN_IN = 23;
  localparam int N_OUT_FN = 16;
  localparam int N_SRC = 128;

  typedef logic [IN_SEL_W-1:0] ppr_in_sel_t;
  typedef logic [OUT_SEL_W-1:0] ppr_out_sel_t;

  // reset values: ground on inputs, null on outputs
  localparam ppr_in_sel_t IN_SEL_RST = 7'h00;
  localparam ppr_out_sel_t OUT_SEL_RST = 6'h00;

  // internal sources on the input side
  localparam ppr_in_sel_t SRC_GND = 7'h00;
  localparam ppr_in_sel_t SRC_CMP1 = 7'h01;
  localparam ppr_in_sel_t SRC_CMP2 = 7'h02;
  localparam ppr_in_sel_t SRC_CMP3 = 7'h03;
  localparam ppr_in_sel_t SRC_CMP4 = 7'h04;
  localparam ppr_in_sel_t SRC_TRG_A = 7'h06;
  localparam ppr_in_sel_t SRC_TRG_B = 7'h07;

  // codes of the remappable_io_pin set, in port order
  localparam ppr_in_sel_t IO_PIN_CODE [N_IO] = '{
    7'h14, 7'h23, 7'h24, 7'h25, 7'h26, 7'h27,
    7'h28, 7'h29, 7'h36, 7'h76, 7'h78};
  // codes of the remappable_input_only_pin set, in port order
  localparam ppr_in_sel_t INO_PIN_CODE [N_INO] = '{
    7'h18, 7'h19, 7'h20, 7'h21, 7'h22, 7'h33, 7'h34, 7'h35};

  // output function codes, index k selects fn_out[k]
  localparam ppr_out_sel_t OUT_NULL = 6'h00;
  localparam ppr_out_sel_t OUT_FN_CODE [N_OUT_FN] = '{
    6'h01, 6'h03, 6'h08, 6'h09, 6'h0A, 6'h10, 6'h11, 6'h12,
    6'h13, 6'h18, 6'h19, 6'h1A, 6'h2D, 6'h2F, 6'h31, 6'h32};

  // peripheral input slots (23 in total)
  localparam int EXT_IRQ_ONE_IDX = 0;
  localparam int EXT_IRQ_TWO_IDX = 1;
  localparam int TIMER2_EXT_CLOCK_IDX = 2;
  localparam int COMPARE_FAULT_A_IDX = 7;
  localparam int PWM_FAULT_ONE_IDX = 8;
  localparam int ENCODER_PHASE_A_IDX = 10;
  localparam int SERIAL1_RECEIVE_IDX = 14;
  localparam int PWM_SYNC_INPUT_IDX = 19;
  localparam int DEADTIME_COMP_ONE_IDX = 20;

endpackage : ppr_pkg

// [ppr_out_if.sv]
`timescale 1ns/1ps
// carries output selectors and peripheral outputs to the output mux
interface ppr_out_if;
  ppr_pkg::ppr_out_sel_t sel [ppr_pkg::N_IO];
  logic [ppr_pkg::N_OUT_FN-1:0] fn_out;
  logic [ppr_pkg::N_IO-1:0] active;
  logic [ppr_pkg::N_IO-1:0] data;
  modport ctrl (output sel, output fn_out, input active, input data);
  modport mux (input sel, input fn_out, output active, output data);
endinterface : ppr_out_if

// [ppr_out_mux.sv]
`timescale 1ns/1ps
module ppr_out_mux (
  ppr_out_if.mux bus
);

  // returns {active, data}; unknown codes act as the null output
  function automatic logic [1:0] ppr_pick(
    input ppr_pkg::ppr_out_sel_t sel,
    input logic [ppr_pkg::N_OUT_FN-1:0] fn
  );
    logic [1:0] r;
    r = 2'h0;
    for (int k = 0; k < ppr_pkg::N_OUT_FN; k++) begin
      if (sel == ppr_pkg::OUT_FN_CODE[k]) begin
        r = {1'b1, fn[k]};
      end
    end
    return r;
  endfunction : ppr_pick

  // one mux per pin; any function may feed many pins at once
  for (genvar p = 0; p < ppr_pkg::N_IO; p++) begin : g_pin
    logic [1:0] pick;
    always_comb begin
      pick = ppr_pick(bus.sel[p], bus.fn_out);
    end
    assign bus.active[p] = pick[1];
    assign bus.data[p] = pick[0];
  end

endmodule : ppr_out_mux

// [ppr_top.sv]
`timescale 1ns/1ps
// Function
// - remappable peripherals reach no pin until software assigns one
// - dedicated functions stay on their fixed pin when enabled
// - active remapped output beats the port function but loses to a dedicated output
// - remapping never overrides an enabled analog function on a pin
// - input routing and output routing have separate selector sets
// - each peripheral input owns one selector naming its source
// - 7-bit input selector value n routes pin n to the input
// - codes 1..4 give comparators, 6 and 7 trigger-generator outputs
// - fault one selector value 1 connects comparator one internally
// - input code 0 ties the peripheral input low
// - each output-capable pin owns a 6-bit function selector
// - output selector resets to zero, the null output
// - only digital peripherals are offered through the fabric
// - i2c, pwm outputs and analog modules stay on dedicated pins
// - code 0 leaves the port function, code 1 serial one transmit
// - no lockout: one source many inputs, one output many pins
// - dedicated output on a pin beats any remapped output
// - remapped output overrides direction; remapped inputs do not
module ppr_top (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic cfg_wr,
  input wire logic cfg_out_sel,
  input wire logic [ppr_pkg::IDX_W-1:0] cfg_idx,
  input wire logic [ppr_pkg::IN_SEL_W-1:0] cfg_val,
  input wire logic cfg_rd_out,
  input wire logic [ppr_pkg::IDX_W-1:0] cfg_rd_idx,
  output logic [ppr_pkg::IN_SEL_W-1:0] cfg_rd_data,
  input wire logic [ppr_pkg::N_IO-1:0] io_pin_in,
  output logic [ppr_pkg::N_IO-1:0] io_pin_out,
  output logic [ppr_pkg::N_IO-1:0] io_pin_oe,
  input wire logic [ppr_pkg::N_INO-1:0] ino_pin_in,
  input wire logic [ppr_pkg::N_IO-1:0] io_analog_en,
  input wire logic [ppr_pkg::N_INO-1:0] ino_analog_en,
  input wire logic [ppr_pkg::N_IO-1:0] io_ded_oe,
  input wire logic [ppr_pkg::N_IO-1:0] io_ded_out,
  input wire logic [ppr_pkg::N_IO-1:0] io_port_oe,
  input wire logic [ppr_pkg::N_IO-1:0] io_port_lat,
  output logic [ppr_pkg::N_IO-1:0] io_pin_level,
  output logic [ppr_pkg::N_INO-1:0] ino_pin_level,
  output logic [ppr_pkg::N_IO-1:0] io_remap_owned,
  input wire logic [3:0] cmp_out,
  input wire logic [1:0] trg_out,
  input wire logic [ppr_pkg::N_OUT_FN-1:0] fn_out,
  output logic [ppr_pkg::N_PIN_IN-1:0] periph_in
);

  ppr_pkg::ppr_in_sel_t in_sel_reg [ppr_pkg::N_PIN_IN];
  ppr_pkg::ppr_out_sel_t out_sel_reg [ppr_pkg::N_IO];
  logic [ppr_pkg::N_IO-1:0] io_s1_reg, io_s2_reg;
  logic [ppr_pkg::N_INO-1:0] ino_s1_reg, ino_s2_reg;
  logic [ppr_pkg::N_IO-1:0] io_dig, out_next, oe_next;
  logic [ppr_pkg::N_INO-1:0] ino_dig;
  logic [ppr_pkg::N_SRC-1:0] src;
  logic [ppr_pkg::N_PIN_IN-1:0] periph_next;
  logic [ppr_pkg::IN_SEL_W-1:0] rd_next;

  ppr_out_if obus ();

  ppr_out_mux u_out_mux (
    .bus(obus.mux)
  );

  // two separate selector banks, written over the config port
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      for (int i = 0; i < ppr_pkg::N_PIN_IN; i++) begin
        in_sel_reg[i] <= ppr_pkg::IN_SEL_RST;
      end
    end else if (cfg_wr && !cfg_out_sel) begin
      for (int i = 0; i < ppr_pkg::N_PIN_IN; i++) begin
        if (cfg_idx == ppr_pkg::IDX_W'(i)) begin
          in_sel_reg[i] <= cfg_val;
        end
      end
    end
  end

  // out-of-range indices are ignored on both banks
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      for (int p = 0; p < ppr_pkg::N_IO; p++) begin
        out_sel_reg[p] <= ppr_pkg::OUT_SEL_RST;
      end
    end else if (cfg_wr && cfg_out_sel) begin
      for (int p = 0; p < ppr_pkg::N_IO; p++) begin
        if (cfg_idx == ppr_pkg::IDX_W'(p)) begin
          out_sel_reg[p] <= cfg_val[ppr_pkg::OUT_SEL_W-1:0];
        end
      end
    end
  end

  // selector readback, zero for unmapped indices
  always_comb begin
    rd_next = '0;
    for (int i = 0; i < ppr_pkg::N_PIN_IN; i++) begin
      if (!cfg_rd_out && cfg_rd_idx == ppr_pkg::IDX_W'(i)) begin
        rd_next = in_sel_reg[i];
      end
    end
    for (int p = 0; p < ppr_pkg::N_IO; p++) begin
      if (cfg_rd_out && cfg_rd_idx == ppr_pkg::IDX_W'(p)) begin
        rd_next = {1'b0, out_sel_reg[p]};
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cfg_rd_data <= '0;
    end else begin
      cfg_rd_data <= rd_next;
    end
  end

  // pads are asynchronous: two flops before any logic looks at them
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      io_s1_reg <= '0;
      io_s2_reg <= '0;
      ino_s1_reg <= '0;
      ino_s2_reg <= '0;
    end else begin
      io_s1_reg <= io_pin_in;
      io_s2_reg <= io_s1_reg;
      ino_s1_reg <= ino_pin_in;
      ino_s2_reg <= ino_s1_reg;
    end
  end

  // analog mode kills the digital input buffer
  assign io_dig = io_s2_reg & ~io_analog_en;
  assign ino_dig = ino_s2_reg & ~ino_analog_en;
  assign io_pin_level = io_dig;
  assign ino_pin_level = ino_dig;

  // source table; unimplemented codes read as ground
  always_comb begin
    src = '0;
    src[ppr_pkg::SRC_CMP1] = cmp_out[0];
    src[ppr_pkg::SRC_CMP2] = cmp_out[1];
    src[ppr_pkg::SRC_CMP3] = cmp_out[2];
    src[ppr_pkg::SRC_CMP4] = cmp_out[3];
    src[ppr_pkg::SRC_TRG_A] = trg_out[0];
    src[ppr_pkg::SRC_TRG_B] = trg_out[1];
    for (int p = 0; p < ppr_pkg::N_IO; p++) begin
      src[ppr_pkg::IO_PIN_CODE[p]] = io_dig[p];
    end
    for (int q = 0; q < ppr_pkg::N_INO; q++) begin
      src[ppr_pkg::INO_PIN_CODE[q]] = ino_dig[q];
    end
  end

  // any source may feed any number of inputs
  always_comb begin
    for (int i = 0; i < ppr_pkg::N_PIN_IN; i++) begin
      periph_next[i] = src[in_sel_reg[i]];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      periph_in <= '0;
    end else begin
      periph_in <= periph_next;
    end
  end

  // feed the output mux
  always_comb begin
    for (int p = 0; p < ppr_pkg::N_IO; p++) begin
      obus.sel[p] = out_sel_reg[p];
    end
    obus.fn_out = fn_out;
  end

  // pin owner: dedicated, then remap unless analog, then port
  always_comb begin
    for (int p = 0; p < ppr_pkg::N_IO; p++) begin
      if (io_ded_oe[p]) begin
        out_next[p] = io_ded_out[p];
        oe_next[p] = 1'b1;
      end else if (obus.active[p] && !io_analog_en[p]) begin
        out_next[p] = obus.data[p];
        oe_next[p] = 1'b1;
      end else begin
        out_next[p] = io_port_lat[p];
        oe_next[p] = io_port_oe[p];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      io_pin_out <= '0;
      io_pin_oe <= '0;
      io_remap_owned <= '0;
    end else begin
      io_pin_out <= out_next;
      io_pin_oe <= oe_next;
      io_remap_owned <= obus.active & ~io_ded_oe & ~io_analog_en;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence fault_write_s;
    cfg_wr && !cfg_out_sel
      && cfg_idx == ppr_pkg::IDX_W'(ppr_pkg::PWM_FAULT_ONE_IDX);
  endsequence
  sequence rx_on_pin0_s;
    (in_sel_reg[ppr_pkg::SERIAL1_RECEIVE_IDX] == ppr_pkg::IO_PIN_CODE[0]
      && !io_analog_en[0])[*4];
  endsequence

  sel_write_a: assert property (fault_write_s |=>
    in_sel_reg[ppr_pkg::PWM_FAULT_ONE_IDX] == $past(cfg_val))
    else $error("fault selector did not take the write");
  gnd_route_a: assert property (
    in_sel_reg[ppr_pkg::PWM_FAULT_ONE_IDX] == ppr_pkg::SRC_GND
      |=> !periph_in[ppr_pkg::PWM_FAULT_ONE_IDX])
    else $error("ground code did not give low");
  cmp_fault_a: assert property (
    in_sel_reg[ppr_pkg::PWM_FAULT_ONE_IDX] == ppr_pkg::SRC_CMP1
      |=> periph_in[ppr_pkg::PWM_FAULT_ONE_IDX] == $past(cmp_out[0]))
    else $error("comparator one not routed to fault one");
  trig_route_a: assert property (
    in_sel_reg[ppr_pkg::SERIAL1_RECEIVE_IDX] == ppr_pkg::SRC_TRG_B
      |=> periph_in[ppr_pkg::SERIAL1_RECEIVE_IDX] == $past(trg_out[1]))
    else $error("trigger output b not routed");
  pin_route_a: assert property (rx_on_pin0_s |->
    periph_in[ppr_pkg::SERIAL1_RECEIVE_IDX] == $past(io_pin_in[0], 3))
    else $error("pin not routed to receive input after three cycles");
  ded_wins_a: assert property (io_ded_oe[0] |=>
    io_pin_oe[0] && io_pin_out[0] == $past(io_ded_out[0]))
    else $error("dedicated output lost the pin");
  remap_wins_a: assert property (
    !io_ded_oe[1] && !io_analog_en[1] && obus.active[1]
      |=> io_pin_oe[1] && io_pin_out[1] == $past(obus.data[1]))
    else $error("remapped output did not own the pin");
  analog_block_a: assert property (
    io_analog_en[2] && !io_ded_oe[2] && !io_port_oe[2] |=> !io_pin_oe[2])
    else $error("remap drove an analog pin");
  null_out_a: assert property (
    out_sel_reg[3] == ppr_pkg::OUT_NULL && !io_ded_oe[3] && !io_port_oe[3]
      |=> !io_pin_oe[3])
    else $error("null selector drove the pin");

endmodule : ppr_top

// [ppr_pad_model.sv]
`timescale 1ns/1ps
// pads and the world beyond them; a driven pad reads back its own drive
module ppr_pad_model (
  input wire logic [10:0] ext_io,
  input wire logic [7:0] ext_ino,
  input wire logic [10:0] io_pin_out,
  input wire logic [10:0] io_pin_oe,
  output logic [10:0] io_pin_in,
  output logic [7:0] ino_pin_in
);
  // wire level from both parties; outside world never fights a drive
  assign io_pin_in = (io_pin_oe & io_pin_out) | (~io_pin_oe & ext_io);
  assign ino_pin_in = ext_ino;
endmodule : ppr_pad_model

// [test_peripheral_pin_remap.sv]
`timescale 1ns/1ps
module test_peripheral_pin_remap;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic cfg_wr = 1'b0;
  logic cfg_out_sel = 1'b0;
  logic cfg_rd_out = 1'b0;
  logic [4:0] cfg_idx = 5'h00;
  logic [4:0] cfg_rd_idx = 5'h00;
  logic [6:0] cfg_val = 7'h00;
  logic [6:0] cfg_rd_data;
  logic [10:0] io_pin_in, io_pin_out, io_pin_oe, io_pin_level, io_remap_owned;
  logic [10:0] io_analog_en = 11'h000;
  logic [10:0] io_ded_oe = 11'h000;
  logic [10:0] io_ded_out = 11'h000;
  logic [10:0] io_port_oe = 11'h000;
  logic [10:0] io_port_lat = 11'h000;
  logic [10:0] ext_io = 11'h000;
  logic [7:0] ext_ino = 8'h00;
  logic [7:0] ino_analog_en = 8'h00;
  logic [7:0] ino_pin_in, ino_pin_level;
  logic [3:0] cmp_out = 4'h0;
  logic [1:0] trg_out = 2'h0;
  logic [5:0] src_vec;
  logic [15:0] fn_out = 16'h0000;
  logic [22:0] periph_in;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int p;
  ppr_top ppr_top_inst (.core_clk, .nrst, .cfg_wr, .cfg_out_sel, .cfg_idx,
    .cfg_val, .cfg_rd_out, .cfg_rd_idx, .cfg_rd_data, .io_pin_in,
    .io_pin_out, .io_pin_oe, .ino_pin_in, .io_analog_en, .ino_analog_en,
    .io_ded_oe, .io_ded_out, .io_port_oe, .io_port_lat, .io_pin_level,
    .ino_pin_level, .io_remap_owned, .cmp_out, .trg_out, .fn_out,
    .periph_in);
  ppr_pad_model ppr_pad_model_inst (.ext_io, .ext_ino, .io_pin_out,
    .io_pin_oe, .io_pin_in, .ino_pin_in);
  always #2.5 core_clk = ~core_clk;
  // hang guard, generous against a few hundred cycles of real work
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fail_count++;
      stop_test();
    end
  end
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  task check(input string what, input logic [31:0] seen,
             input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  // settle wait covers the two pad flops plus the output register
  task settle;
    repeat (4) @(negedge core_clk);
  endtask : settle
  // one-cycle write strobe, then let routing settle
  task wr(input logic bank, input logic [4:0] idx, input logic [6:0] val);
    @(negedge core_clk);
    cfg_wr = 1'b1;
    cfg_out_sel = bank;
    cfg_idx = idx;
    cfg_val = val;
    @(negedge core_clk);
    cfg_wr = 1'b0;
    settle();
  endtask : wr
  initial begin
    repeat (2) @(negedge core_clk);
    nrst = 1'b1;
    @(negedge core_clk);
    check("periph_in", periph_in, 0);
    check("pin_oe", io_pin_oe, 0);
    check("owned", io_remap_owned, 0);
    // every internal source into fault one, with both polarities
    for (int pass = 0; pass < 2; pass++) begin
      cmp_out = pass ? 4'hA : 4'h5;
      trg_out = pass ? 2'h1 : 2'h2;
      src_vec = {trg_out, cmp_out};
      for (int k = 0; k < 6; k++) begin
        wr(1'b0, 5'(ppr_pkg::PWM_FAULT_ONE_IDX),
           k < 4 ? 7'(k + 1) : 7'(k + 2));
        check("fault_one", periph_in[8], src_vec[k]);
      end
    end
    cmp_out = 4'hF;
    trg_out = 2'h3;
    wr(1'b0, 5'(ppr_pkg::PWM_FAULT_ONE_IDX), 7'h05);
    check("unimpl", periph_in[8], 0);
    wr(1'b0, 5'(ppr_pkg::PWM_FAULT_ONE_IDX), ppr_pkg::SRC_GND);
    check("ground", periph_in[8], 0);
    // each io pad into two inputs at once
    for (int i = 0; i < 11; i++) begin
      ext_io = 11'h001 << i;
      wr(1'b0, 5'(ppr_pkg::SERIAL1_RECEIVE_IDX), ppr_pkg::IO_PIN_CODE[i]);
      wr(1'b0, 5'(ppr_pkg::EXT_IRQ_ONE_IDX), ppr_pkg::IO_PIN_CODE[i]);
      check("rx_hi", periph_in[14], 1);
      check("irq_hi", periph_in[0], 1);
      check("level", io_pin_level, ext_io);
      ext_io = ~(11'h001 << i);
      settle();
      check("rx_lo", periph_in[14], 0);
    end
    for (int i = 0; i < 8; i++) begin
      ext_ino = 8'h01 << i;
      wr(1'b0, 5'(ppr_pkg::SERIAL1_RECEIVE_IDX), ppr_pkg::INO_PIN_CODE[i]);
      check("ino_hi", periph_in[14], 1);
      ext_ino = ~(8'h01 << i);
      settle();
      check("ino_lo", periph_in[14], 0);
    end
    // analog mode hides the pad from remapped inputs
    wr(1'b0, 5'(ppr_pkg::SERIAL1_RECEIVE_IDX), ppr_pkg::IO_PIN_CODE[3]);
    ext_io = 11'h7FF;
    io_analog_en = 11'h008;
    settle();
    check("an_in", periph_in[14], 0);
    check("an_lvl", io_pin_level[3], 0);
    io_analog_en = 11'h000;
    // every output code; port direction left as input on purpose
    for (int k = 0; k < 16; k++) begin
      p = k % 11;
      wr(1'b1, 5'(p), {1'b0, ppr_pkg::OUT_FN_CODE[k]});
      fn_out = 16'h0001 << k;
      settle();
      check("out_hi", io_pin_out[p], 1);
      check("out_oe", io_pin_oe[p], 1);
      check("owned", io_remap_owned[p], 1);
      fn_out = 16'h0000;
      settle();
      check("out_lo", io_pin_out[p], 0);
    end
    // one output onto two pins
    wr(1'b1, 5'h00, {1'b0, ppr_pkg::OUT_FN_CODE[0]});
    wr(1'b1, 5'h01, {1'b0, ppr_pkg::OUT_FN_CODE[0]});
    fn_out = 16'h0001;
    settle();
    check("two_pins", io_pin_out[1:0], 2'h3);
    // pin 2 still holds an active selector, so analog must block it
    io_ded_oe = 11'h001;
    io_analog_en = 11'h006;
    settle();
    check("ded_out", io_pin_out[0], 0);
    check("ded_own", io_remap_owned[0], 0);
    check("an_own", io_remap_owned[1], 0);
    check("an_oe", io_pin_oe[1], 0);
    check("an_oe2", io_pin_oe[2], 0);
    io_analog_en = 11'h000;
    io_port_oe = 11'h002;
    io_port_lat = 11'h002;
    wr(1'b1, 5'h01, {1'b0, ppr_pkg::OUT_NULL});
    check("port_out", io_pin_out[1], 1);
    check("port_own", io_remap_owned[1], 0);
    // readback of both banks and a refused index
    wr(1'b0, 5'h1E, 7'h14);
    cfg_rd_out = 1'b1;
    cfg_rd_idx = 5'h00;
    settle();
    check("rd_out", cfg_rd_data, {1'b0, ppr_pkg::OUT_FN_CODE[0]});
    cfg_rd_out = 1'b0;
    settle();
    check("rd_in", cfg_rd_data, ppr_pkg::IO_PIN_CODE[10]);
    cfg_rd_idx = 5'h07;
    settle();
    check("rd_ref", cfg_rd_data, 0);
    cfg_rd_idx = 5'h1E;
    settle();
    check("rd_bad", cfg_rd_data, 0);
    stop_test();
  end
endmodule : test_peripheral_pin_remap
